// ==== bench/qdcd_host_model.sv ====
// Behavioural host serial controller that drives the three-wire frame link.
// Assumes the decoder takes data on falling serial clock edges.
`timescale 1ns/1ps
module qdcd_host_model
(
	output logic sclk,
	output logic frameSelN,
	output logic dataIn
);
	// The link idles with select high and the serial clock standing still.
	initial
	begin
		sclk      = 1'h0;
		frameSelN = 1'h1;
		dataIn    = 1'h0;
	end

	// Sends the first nBits of a word, then extra clocks, then releases select.
	// Released data is inverted so a stale bit can never pass for a fresh one.
	task automatic send(input logic [23:0] w, input int nBits, input int extra);
		frameSelN = 1'h0;
		#80;
		for (int i = 0; i < nBits + extra; i++)
		begin
			sclk   = 1'h1;
			dataIn = (i < nBits) ? w[23-i] : ~dataIn;
			#80;
			sclk = 1'h0;
			#80;
		end
		#80;
		frameSelN = 1'h1;
		dataIn    = ~dataIn;
		#240;
	endtask
endmodule

// ==== bench/qdcd_tb_top.sv ====
// Self-checking bench for the quad converter command decoder.
// Assumes the host model drives the link and a reference model tracks state.
`timescale 1ns/1ps
module qdcd_tb_top;
	logic             clk, rst, loadAllStrobe, resetLevelSelect, regWr, regRd;
	logic             sclkPin, frameSelN, dataIn, refEnable;
	logic [7:0]       regAddr;
	logic [31:0]      regWrData, regRdData, rd;
	logic [3:0][13:0] chanCode;
	logic [3:0][1:0]  chanPdMode;
	logic [13:0]      bufCode[4], outCode[4];
	logic [1:0]       bufMode[4], outMode[4];
	int               bad_count = 0;
	int               tests_run = 0;

	qdcd_top qdcd_top_inst (.clk(clk), .rst(rst), .sclkPin(sclkPin), .frameSelN(frameSelN),
		.dataIn(dataIn), .loadAllStrobe(loadAllStrobe), .resetLevelSelect(resetLevelSelect),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .chanCode(chanCode), .chanPdMode(chanPdMode),
		.refEnable(refEnable));
	qdcd_host_model qdcd_host_model_inst (.sclk(sclkPin), .frameSelN(frameSelN), .dataIn(dataIn));

	// 125 MHz system clock.
	initial
	begin
		clk = 1'h0;
	end
	always #4 clk = ~clk;

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic regRead(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regRd   <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'h0;
		#1 d = regRdData;
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr     <= 1'h1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'h0;
	endtask

	// Frame builder; the two ignored low bits are set to show they are dropped.
	function automatic logic [23:0] mk(logic [1:0] ld, logic [1:0] sel, logic pd, logic [13:0] v);
		return {2'h0, ld, 1'h0, sel, pd, v, 2'h3};
	endfunction

	// Reference model: a power-down entry keeps the old code, pattern 100 is high-Z.
	task automatic setBuf(input int s, input logic [23:0] w);
		bufMode[s] = w[16] ? ((w[15:14] == 2'h0) ? 2'h3 : w[15:14]) : 2'h0;
		if (!w[16])
			bufCode[s] = w[15:2];
	endtask

	task automatic loadAll();
		for (int i = 0; i < 4; i++)
		begin
			outCode[i] = bufCode[i];
			outMode[i] = bufMode[i];
		end
	endtask

	task automatic apply(input logic [23:0] w);
		int s;
		s = w[18:17];
		if (w[21:20] == 2'h3)
		begin
			if (w[18])
				for (int i = 0; i < 4; i++)
					setBuf(i, w);
			loadAll();
		end
		else
		begin
			setBuf(s, w);
			if (w[21:20] == 2'h1)
			begin
				outCode[s] = bufCode[s];
				outMode[s] = bufMode[s];
			end
			if (w[21:20] == 2'h2)
				loadAll();
		end
	endtask

	task automatic modelReset(input logic lvl);
		for (int i = 0; i < 4; i++)
		begin
			bufCode[i] = lvl ? qdcd_pkg::MID_SCALE : qdcd_pkg::ZERO_SCALE;
			bufMode[i] = 2'h0;
		end
		loadAll();
	endtask

	// Compares every output register and every buffer with the model.
	task automatic checkAll();
		for (int i = 0; i < 4; i++)
		begin
			chk("chanCode", {18'h0, outCode[i]}, {18'h0, chanCode[i]});
			chk("chanPdMode", {30'h0, outMode[i]}, {30'h0, chanPdMode[i]});
			regRead({qdcd_pkg::BUF_PAGE, 4'h0} + 8'(i * 4), rd);
			chk("bufWord", {16'h0, bufMode[i], bufCode[i]}, rd);
		end
	endtask

	// Outputs settle within a few cycles of the last falling edge.
	task automatic frame(input logic [23:0] w);
		qdcd_host_model_inst.send(w, 24, 0);
		cycles(8);
		apply(w);
		checkAll();
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic sc_reset();
		modelReset(1'h0);
		checkAll();
		chk("refEnable", 32'h1, {31'h0, refEnable});
		regRead(qdcd_pkg::ADDR_STATUS, rd);
		chk("status", 32'h1, rd);
	endtask

	task automatic sc_store();
		for (int s = 0; s < 4; s++)
			frame(mk(2'h0, 2'(s), 1'h0, 14'h0111 * 14'(s + 1)));
		frame(mk(2'h2, 2'h3, 1'h0, 14'h3ABC));
		frame(mk(2'h1, 2'h1, 1'h0, 14'h2A55));
	endtask

	task automatic sc_powerdown();
		for (int p = 0; p < 4; p++)
			frame(mk(2'h0, 2'h2, 1'h1, {2'(p), 12'h000}));
		frame(mk(2'h1, 2'h1, 1'h1, 14'h1000));
	endtask

	task automatic sc_broadcast();
		frame(mk(2'h0, 2'h0, 1'h0, 14'h0F0F));
		frame(mk(2'h3, 2'h0, 1'h0, 14'h3FFF) | 24'hC00000);
		frame(mk(2'h3, 2'h2, 1'h0, 14'h1357));
		frame(mk(2'h3, 2'h2, 1'h1, 14'h3000));
	endtask

	task automatic sc_abort();
		qdcd_host_model_inst.send(mk(2'h1, 2'h0, 1'h0, 14'h0ABC), 20, 0);
		cycles(8);
		checkAll();
		frame(mk(2'h1, 2'h3, 1'h0, 14'h0246));
		qdcd_host_model_inst.send(mk(2'h1, 2'h0, 1'h0, 14'h0765), 24, 4);
		cycles(8);
		apply(mk(2'h1, 2'h0, 1'h0, 14'h0765));
		checkAll();
	endtask

	task automatic sc_strobe();
		frame(mk(2'h0, 2'h0, 1'h0, 14'h1ABC));
		@(posedge clk);
		loadAllStrobe <= 1'h1;
		cycles(8);
		loadAll();
		checkAll();
		loadAllStrobe <= 1'h0;
	endtask

	task automatic sc_regs();
		regRead(8'hFC, rd);
		chk("unmapped", 32'h0, rd);
		regRead({qdcd_pkg::OUT_PAGE, 4'h0}, rd);
		chk("outWord", {16'h0, outMode[0], outCode[0]}, rd);
		regWrite(qdcd_pkg::ADDR_CTRL, 32'h0);
		regRead(qdcd_pkg::ADDR_CTRL, rd);
		chk("ctrl", 32'h0, rd);
		qdcd_host_model_inst.send(mk(2'h1, 2'h2, 1'h0, 14'h0001), 24, 0);
		cycles(8);
		checkAll();
		regWrite(qdcd_pkg::ADDR_CTRL, 32'h1);
	endtask

	task automatic sc_rst2();
		@(posedge clk);
		rst              <= 1'h1;
		resetLevelSelect <= 1'h1;
		cycles(8);
		rst <= 1'h0;
		regRead(qdcd_pkg::ADDR_STATUS, rd);
		chk("statusInit", 32'h3, rd);
		cycles(8);
		modelReset(1'h1);
		checkAll();
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial
	begin
		rst              = 1'h1;
		loadAllStrobe    = 1'h0;
		resetLevelSelect = 1'h0;
		regWr            = 1'h0;
		regRd            = 1'h0;
		regAddr          = 8'h00;
		regWrData        = 32'h0;
		cycles(8);
		rst <= 1'h0;
		cycles(6);
		sc_reset();
		sc_store();
		sc_powerdown();
		sc_broadcast();
		sc_abort();
		sc_strobe();
		sc_regs();
		sc_rst2();
		finish_test();
	end

	// A hang counts as a mismatch and ends the run through the same report.
	initial
	begin
		#500000;
		bad_count++;
		finish_test();
	end
endmodule

// ==== hdl/qdcd_frame_rx.sv ====
// Pin synchroniser and 24-bit serial frame receiver.
// Assumes the serial clock is well below a quarter of clk so each level is seen.
`timescale 1ns/1ps
module qdcd_frame_rx
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sclkPin,
	input  wire logic frameSelN,
	input  wire logic dataIn,
	input  wire logic loadAllStrobe,
	input  wire logic resetLevelSelect,
	qdcd_rx_if.rx     rx
);
	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	logic [4:0] pins;
	logic [4:0] pinMeta_q;
	logic [4:0] pinSync_q;
	logic [4:0] pinPrev_q;
	assign pins = {resetLevelSelect, loadAllStrobe, dataIn, frameSelN, sclkPin};

	// Two stages per pin; the third stage only serves edge detection.
	generate
		for (genvar i = 0; i < 5; i++)
		begin : g_sync
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					pinMeta_q[i] <= 1'h0;
					pinSync_q[i] <= 1'h0;
					pinPrev_q[i] <= 1'h0;
				end
				else
				begin
					pinMeta_q[i] <= pins[i];
					pinSync_q[i] <= pinMeta_q[i];
					pinPrev_q[i] <= pinSync_q[i];
				end
			end
		end
	endgenerate

	logic sclkFall;
	logic selFall;
	logic selRise;
	assign sclkFall = pinPrev_q[0] & ~pinSync_q[0];
	assign selFall  = pinPrev_q[1] & ~pinSync_q[1];
	assign selRise  = ~pinPrev_q[1] & pinSync_q[1];

	// ------------------------------------------------------------------
	// Frame shifter
	// ------------------------------------------------------------------
	qdcd_pkg::qdcd_rxstate_t state_q, state_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [23:0] inputShiftWord_q, inputShiftWord_d;
	logic        valid_q, valid_d;
	logic        ldRise_q, ldRise_d;

	// Shift on falling serial edges, lock after the last one, abort on early release.
	always_comb
	begin
		state_d          = state_q;
		cnt_d            = cnt_q;
		inputShiftWord_d = inputShiftWord_q;
		valid_d          = 1'h0;
		ldRise_d         = pinSync_q[3] & ~pinPrev_q[3];
		if (!rx.listenEn)
		begin
			state_d = qdcd_pkg::RX_IDLE;
		end
		else if (selFall)
		begin
			state_d          = qdcd_pkg::RX_SHIFT;
			cnt_d            = 5'h00;
			inputShiftWord_d = 24'h000000;
		end
		else
		begin
			unique case (state_q)
				qdcd_pkg::RX_IDLE:
					state_d = qdcd_pkg::RX_IDLE;
				qdcd_pkg::RX_SHIFT:
					if (selRise)
					begin
						state_d          = qdcd_pkg::RX_IDLE;
						inputShiftWord_d = 24'h000000;
					end
					else if (sclkFall)
					begin
						inputShiftWord_d = {inputShiftWord_q[22:0], pinSync_q[2]};
						cnt_d            = cnt_q + 5'h01;
						if (cnt_q == qdcd_pkg::LAST_EDGE_IDX)
						begin
							state_d = qdcd_pkg::RX_LOCKED;
							valid_d = 1'h1;
						end
					end
				qdcd_pkg::RX_LOCKED:
					state_d = qdcd_pkg::RX_LOCKED;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q          <= qdcd_pkg::RX_IDLE;
			cnt_q            <= 5'h00;
			inputShiftWord_q <= 24'h000000;
			valid_q          <= 1'h0;
			ldRise_q         <= 1'h0;
		end
		else
		begin
			state_q          <= state_d;
			cnt_q            <= cnt_d;
			inputShiftWord_q <= inputShiftWord_d;
			valid_q          <= valid_d;
			ldRise_q         <= ldRise_d;
		end
	end

	assign rx.frameValid  = valid_q;
	assign rx.frameWord   = inputShiftWord_q;
	assign rx.loadAllRise = ldRise_q;
	assign rx.rstLevel    = pinSync_q[4];

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence lastEdge;
		state_q == qdcd_pkg::RX_SHIFT && !selFall && !selRise && sclkFall &&
			cnt_q == qdcd_pkg::LAST_EDGE_IDX && rx.listenEn;
	endsequence

	chk_frame_done: assert property (@(posedge clk) disable iff (rst)
		lastEdge |=> valid_q && state_q == qdcd_pkg::RX_LOCKED)
		else $error("Frame not delivered on its last falling edge.");
	chk_lock_hold: assert property (@(posedge clk) disable iff (rst)
		state_q == qdcd_pkg::RX_LOCKED && !selFall |=> $stable(inputShiftWord_q) && !valid_q)
		else $error("Locked shift word changed.");
	chk_abort_clear: assert property (@(posedge clk) disable iff (rst)
		state_q == qdcd_pkg::RX_SHIFT && selRise && !selFall && rx.listenEn
		|=> inputShiftWord_q == 24'h000000 && !valid_q [*2])
		else $error("Aborted frame was not discarded.");
endmodule

// ==== hdl/qdcd_top.sv ====
// Command decoder and double-buffered channel registers of a quad converter.
// Assumes the link pins are asynchronous and the register port is on clk.
//
// Overview of operation
// - Frames are 24 bits MSB first, sampled on falling serial clock edges.
// - After the 24th falling edge the shift word locks until a new frame.
// - Store mode with flag clear writes data to the selected buffer only.
// - Store mode with flag set writes a power-down entry to that buffer.
// - Update mode with flag clear writes buffer and output of the channel.
// - Update mode with flag set applies power-down to buffer and output.
// - Load-all mode writes the selected buffer, then copies all buffers out.
// - Broadcast with upper select clear copies all buffers to outputs.
// - Broadcast with upper select set writes data to every buffer and output.
// - Broadcast with upper select and flag set applies power-down to every buffer and output.
// - Flag plus two bits: 101 1k, 110 100k, 111 high impedance.
// - Host holds select low 24 edges; update happens on the 24th edge.
// - Early select release clears the shift word and discards the frame.
// - Reset sets outputs to zero or mid scale by the level select pin.
// - Reset returns every internal register to its power-on value; listen and reference enable come up set.
// - Reference enable is on after reset and stays on.
// - Frame updates are synchronous; host ties the strobe low otherwise.
// - Rising load strobe copies every buffer into its output at once.
// - An untouched buffer keeps its channel output unchanged on the strobe.
// - Buffers stay separate from outputs until a load happens.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module qdcd_top
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              sclkPin,
	input  wire logic              frameSelN,
	input  wire logic              dataIn,
	input  wire logic              loadAllStrobe,
	input  wire logic              resetLevelSelect,
	input  wire logic [7:0]        regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [31:0]       regRdData,
	output logic      [3:0][13:0]  chanCode,
	output logic      [3:0][1:0]   chanPdMode,
	output logic                   refEnable
);
	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	qdcd_rx_if rx ();

	qdcd_frame_rx u_rx
	(
		.clk              (clk),
		.rst              (rst),
		.sclkPin          (sclkPin),
		.frameSelN        (frameSelN),
		.dataIn           (dataIn),
		.loadAllStrobe    (loadAllStrobe),
		.resetLevelSelect (resetLevelSelect),
		.rx               (rx.rx)
	);

	// ------------------------------------------------------------------
	// Frame field decode
	// ------------------------------------------------------------------
	logic                            frmValid;
	qdcd_pkg::qdcd_load_t            frmLoad;
	logic [1:0]                      frmSel;
	logic                            frmPd;
	logic                            frmBcastData;
	logic [qdcd_pkg::CODE_W-1:0]     frmData;

	assign frmValid     = rx.frameValid;
	assign frmLoad      = qdcd_pkg::qdcd_load_t'({rx.frameWord[qdcd_pkg::LD_HI_POS],
		rx.frameWord[qdcd_pkg::LD_LO_POS]});
	assign frmSel       = {rx.frameWord[qdcd_pkg::SEL_HI_POS], rx.frameWord[qdcd_pkg::SEL_LO_POS]};
	assign frmPd        = rx.frameWord[qdcd_pkg::PD_FLAG_POS];
	assign frmBcastData = rx.frameWord[qdcd_pkg::SEL_HI_POS];
	assign frmData      = rx.frameWord[qdcd_pkg::DATA_MSB_POS:qdcd_pkg::DATA_LSB_POS];

	// Builds the entry a frame leaves in a channel. A power-down entry keeps the
	// old code, but leaving power-down loads the code carried by the new frame.
	function automatic qdcd_pkg::qdcd_entry_t frameEntry(
		input qdcd_pkg::qdcd_entry_t old,
		input logic [23:0]           w
	);
		qdcd_pkg::qdcd_entry_t e;
		logic [1:0]            s;
		e = old;
		s = {w[qdcd_pkg::PD_SEL_HI_POS], w[qdcd_pkg::PD_SEL_LO_POS]};
		if (!w[qdcd_pkg::PD_FLAG_POS])
		begin
			e.mode = qdcd_pkg::PDM_NORMAL;
			e.code = w[qdcd_pkg::DATA_MSB_POS:qdcd_pkg::DATA_LSB_POS];
		end
		else if (s == 2'h1)
			e.mode = qdcd_pkg::PDM_1K;
		else if (s == 2'h2)
			e.mode = qdcd_pkg::PDM_100K;
		else
			e.mode = qdcd_pkg::PDM_HIZ; // Pattern 100 is undefined; treated as open.
		return e;
	endfunction

	// ------------------------------------------------------------------
	// Channel buffers and output registers
	// ------------------------------------------------------------------
	qdcd_pkg::qdcd_entry_t [3:0] bufReg_q, bufReg_d;
	qdcd_pkg::qdcd_entry_t [3:0] outReg_q, outReg_d;
	logic [1:0]                  initCnt_q, initCnt_d;
	qdcd_pkg::qdcd_entry_t       lvlEntry;

	// The level select pin is caught only after reset release, once synchronised.
	assign lvlEntry = '{mode: qdcd_pkg::PDM_NORMAL,
		code: rx.rstLevel ? qdcd_pkg::MID_SCALE : qdcd_pkg::ZERO_SCALE};

	// Frame decode first, then the load strobe copies the freshest buffers.
	always_comb
	begin
		bufReg_d  = bufReg_q;
		outReg_d  = outReg_q;
		initCnt_d = initCnt_q;
		if (initCnt_q != 2'h0)
		begin
			initCnt_d = initCnt_q - 2'h1;
			if (initCnt_q == 2'h1)
			begin
				bufReg_d = {qdcd_pkg::NUM_CH{lvlEntry}};
				outReg_d = {qdcd_pkg::NUM_CH{lvlEntry}};
			end
		end
		else if (frmValid)
		begin
			unique case (frmLoad)
				qdcd_pkg::LD_STORE:
					bufReg_d[frmSel] = frameEntry(bufReg_q[frmSel], rx.frameWord);
				qdcd_pkg::LD_UPDATE:
				begin
					bufReg_d[frmSel] = frameEntry(bufReg_q[frmSel], rx.frameWord);
					outReg_d[frmSel] = frameEntry(bufReg_q[frmSel], rx.frameWord);
				end
				qdcd_pkg::LD_ALL:
				begin
					bufReg_d[frmSel] = frameEntry(bufReg_q[frmSel], rx.frameWord);
					outReg_d         = bufReg_d;
				end
				qdcd_pkg::LD_BCAST:
				begin
					if (frmBcastData)
					begin
						for (int i = 0; i < qdcd_pkg::NUM_CH; i++)
						begin
							bufReg_d[i] = frameEntry(bufReg_q[i], rx.frameWord);
						end
					end
					outReg_d = bufReg_d;
				end
			endcase
		end
		if (rx.loadAllRise && initCnt_q == 2'h0)
		begin
			outReg_d = bufReg_d;
		end
	end

	// Everything clears to zero scale at once; the chosen level follows.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bufReg_q  <= '0;
			outReg_q  <= '0;
			initCnt_q <= qdcd_pkg::INIT_WAIT;
		end
		else
		begin
			bufReg_q  <= bufReg_d;
			outReg_q  <= outReg_d;
			initCnt_q <= initCnt_d;
		end
	end

	generate
		for (genvar c = 0; c < qdcd_pkg::NUM_CH; c++)
		begin : g_out
			assign chanCode[c]   = outReg_q[c].code;
			assign chanPdMode[c] = outReg_q[c].mode;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	logic        listen_q, listen_d;
	logic        refOn_q, refOn_d;
	logic [31:0] rdData_q, rdData_d;

	// No reference command is decoded here, so the enable never drops.
	always_comb
	begin
		listen_d = listen_q;
		refOn_d  = refOn_q;
		rdData_d = 32'h00000000;
		if (regWr && regAddr == qdcd_pkg::ADDR_CTRL)
		begin
			listen_d = regWrData[0];
		end
		if (regRd)
		begin
			if (regAddr == qdcd_pkg::ADDR_CTRL)
				rdData_d = {31'h00000000, listen_q};
			else if (regAddr == qdcd_pkg::ADDR_STATUS)
				rdData_d = {30'h00000000, initCnt_q != 2'h0, refOn_q};
			else if (regAddr[1:0] == 2'h0 && regAddr[7:4] == qdcd_pkg::OUT_PAGE)
				rdData_d = {16'h0000, outReg_q[regAddr[3:2]]};
			else if (regAddr[1:0] == 2'h0 && regAddr[7:4] == qdcd_pkg::BUF_PAGE)
				rdData_d = {16'h0000, bufReg_q[regAddr[3:2]]};
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			listen_q <= qdcd_pkg::LISTEN_RESET;
			refOn_q  <= qdcd_pkg::REF_ON_RESET;
			rdData_q <= 32'h00000000;
		end
		else
		begin
			listen_q <= listen_d;
			refOn_q  <= refOn_d;
			rdData_q <= rdData_d;
		end
	end

	assign rx.listenEn = listen_q;
	assign regRdData   = rdData_q;
	assign refEnable   = refOn_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Quiet means neither the init step nor a strobe copy competes with a frame,
	// so the per-command checks below see the decoder alone.
	logic quiet;
	assign quiet = initCnt_q == 2'h0 && !rx.loadAllRise;

	chk_store_only: assert property (
		frmValid && quiet && frmLoad == qdcd_pkg::LD_STORE && !frmPd
		|=> $stable(outReg_q) && bufReg_q[$past(frmSel)].code == $past(frmData))
		else $error("Store command touched an output or missed its buffer.");
	chk_store_pd: assert property (
		frmValid && quiet && frmLoad == qdcd_pkg::LD_STORE && frmPd
		|=> $stable(outReg_q) && bufReg_q[$past(frmSel)].mode != qdcd_pkg::PDM_NORMAL)
		else $error("Power-down store misbehaved.");
	chk_load_one: assert property (
		frmValid && quiet && frmLoad == qdcd_pkg::LD_UPDATE && !frmPd
		|=> outReg_q[$past(frmSel)].code == $past(frmData) &&
			outReg_q[$past(frmSel)].mode == qdcd_pkg::PDM_NORMAL)
		else $error("Single update did not reach the output.");
	chk_pd_apply: assert property (
		frmValid && quiet && frmLoad == qdcd_pkg::LD_UPDATE && frmPd &&
			rx.frameWord[15:14] == 2'h2
		|=> outReg_q[$past(frmSel)].mode == qdcd_pkg::PDM_100K)
		else $error("Power-down update not applied.");
	chk_load_all: assert property (
		frmValid && initCnt_q == 2'h0 && frmLoad == qdcd_pkg::LD_ALL |=> outReg_q == bufReg_q)
		else $error("Load-all did not copy every buffer.");
	chk_bcast_load: assert property (
		frmValid && initCnt_q == 2'h0 && frmLoad == qdcd_pkg::LD_BCAST && !frmBcastData
		|=> outReg_q == $past(bufReg_q) && $stable(bufReg_q))
		else $error("Broadcast load changed a buffer or missed an output.");
	chk_bcast_data: assert property (
		frmValid && initCnt_q == 2'h0 && frmLoad == qdcd_pkg::LD_BCAST && frmBcastData && !frmPd
		|=> outReg_q[0].code == $past(frmData) && outReg_q[3].code == $past(frmData) &&
			bufReg_q == outReg_q)
		else $error("Broadcast data not written everywhere.");
	chk_strobe_copy: assert property (
		rx.loadAllRise && !frmValid && initCnt_q == 2'h0 |=> outReg_q == $past(bufReg_q))
		else $error("Load strobe did not copy the buffers.");
	chk_ref_on: assert property (
		refEnable == 1'h1)
		else $error("Reference enable dropped.");
	chk_reset_level: assert property (
		initCnt_q == 2'h1 |=> chanCode[0] == ($past(rx.rstLevel) ? qdcd_pkg::MID_SCALE :
			qdcd_pkg::ZERO_SCALE) && chanPdMode[2] == qdcd_pkg::PDM_NORMAL)
		else $error("Reset level not applied.");
	// Between load events nothing may move; a stray write enable would show here.
	chk_quiet_hold: assert property (
		!frmValid && initCnt_q == 2'h0 && !rx.loadAllRise
		|=> $stable(outReg_q) && $stable(bufReg_q))
		else $error("Buffer or output changed without a load event.");
	// Read data clears the cycle after regRd drops, so a stale word is never taken twice.
	chk_read_clear: assert property (
		!regRd |=> regRdData == 32'h00000000)
		else $error("Read data did not return to zero.");
endmodule

// ==== inc/qdcd_pkg.sv ====
// Constants, field positions and types of the quad converter command decoder.
// Assumes a single 125 MHz system clock; all link pins are asynchronous to it.
package qdcd_pkg;
	// ------------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------------
	localparam int         FRAME_BITS    = 24;
	localparam logic [4:0] LAST_EDGE_IDX = 5'h17;
	localparam int         LD_HI_POS     = 21;
	localparam int         LD_LO_POS     = 20;
	localparam int         SEL_HI_POS    = 18;
	localparam int         SEL_LO_POS    = 17;
	localparam int         PD_FLAG_POS   = 16;
	localparam int         PD_SEL_HI_POS = 15;
	localparam int         PD_SEL_LO_POS = 14;
	localparam int         DATA_MSB_POS  = 15;
	localparam int         DATA_LSB_POS  = 2;
	localparam int         CODE_W        = 14;
	localparam int         NUM_CH        = 4;
	// ------------------------------------------------------------------
	// Reset values and register offsets
	// ------------------------------------------------------------------
	localparam logic [13:0] ZERO_SCALE   = 14'h0000;
	localparam logic [13:0] MID_SCALE    = 14'h2000;
	localparam logic        REF_ON_RESET = 1'h1;
	localparam logic        LISTEN_RESET = 1'h1;
	localparam logic [1:0]  INIT_WAIT    = 2'h3;
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS  = 8'h04;
	localparam logic [3:0]  OUT_PAGE     = 4'h1;
	localparam logic [3:0]  BUF_PAGE     = 4'h2;
	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {LD_STORE = 2'h0, LD_UPDATE = 2'h1, LD_ALL = 2'h2,
		LD_BCAST = 2'h3} qdcd_load_t;
	typedef enum logic [1:0] {PDM_NORMAL = 2'h0, PDM_1K = 2'h1, PDM_100K = 2'h2,
		PDM_HIZ = 2'h3} qdcd_pdmode_t;
	typedef struct packed {
		qdcd_pdmode_t      mode;
		logic [CODE_W-1:0] code;
	} qdcd_entry_t;
	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_SHIFT = 2'h1, RX_LOCKED = 2'h3} qdcd_rxstate_t;
endpackage

// ==== inc/qdcd_rx_if.sv ====
// Carrier between the serial receiver and the command core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface qdcd_rx_if;
	logic        frameValid;
	logic [23:0] frameWord;
	logic        loadAllRise;
	logic        rstLevel;
	logic        listenEn;
	modport rx (output frameValid, frameWord, loadAllRise, rstLevel, input listenEn);
	modport core (input frameValid, frameWord, loadAllRise, rstLevel, output listenEn);
endinterface
